/* File: hw/rcsc_pkg.sv */
// rcsc_pkg: shared states, timing constants and reset values for the receiver/card controller
package rcsc_pkg;
  // receiver power states
  typedef enum logic [1:0] {RCSC_RX_DEAD, RCSC_RX_STANDBY, RCSC_RX_OPERATING} rcsc_rx_t;
  // card states as the receiver recognises them
  typedef enum logic [2:0] {
    RCSC_CD_NONE, RCSC_CD_POWERUP, RCSC_CD_CLASSIFY, RCSC_CD_VALID,
    RCSC_CD_INVALID, RCSC_CD_POWEROFF, RCSC_CD_FAIL
  } rcsc_card_t;
  // clock and time base
  localparam int CLK_HZ = 40000000;
  localparam int TICK_PERIOD_MS = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_PERIOD_MS;
  localparam int TIME_W = 40;
  localparam logic [39:0] TIME_RESET = 40'h00_0000_0000;
  // least card power-up settle time before classification starts
  localparam int CARD_SETTLE_US = 50;
  localparam int CARD_SETTLE_CYCLES = (CLK_HZ / 1000000) * CARD_SETTLE_US;
endpackage

/* File: hw/rcsc_time_counter.sv */
// rcsc_time_counter: absolute time counter in ticks with load from time offset table
`timescale 1ns/1ps
`default_nettype none
module rcsc_time_counter
  import rcsc_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
)(
  input wire logic clk_sys, // system clock
  input wire logic reset, // sync reset, active high
  input wire logic run, // count enable level
  input wire logic load, // one-cycle load pulse
  input wire logic [TIME_W-1:0] load_value, // time to load
  output logic [TIME_W-1:0] time_now // current time in ticks
);
  logic [31:0] div_r;
  logic [TIME_W-1:0] time_r;
  wire tick = (div_r == 32'(TICK_DIV - 1));

  // prescaler; a load restarts the tick so the new time is not shortened
  always_ff @(posedge clk_sys)
  begin
    if (reset || load || !run || tick)
      div_r <= 32'h0;
    else
      div_r <= div_r + 32'h1;
  end

  // load wins over a count in the same cycle
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      time_r <= TIME_RESET;
    else if (load)
      time_r <= load_value;
    else if (run && tick)
      time_r <= time_r + TIME_W'(1);
  end

  assign time_now = time_r;
endmodule
`default_nettype wire

/* File: hw/rcsc_controller.sv */
// rcsc_controller: receiver power state and smart card state controller
// What this block does
// - main switch on while Dead moves receiver to Standby
// - main power lost from any state forces Dead
// - optional resume variant returns directly to Operating when Operating was the last state before Dead, and retunes last channel
// - sub power on in Standby moves to Operating
// - sub power off in Operating returns to Standby
// - Standby keeps power-on control, designated-channel messages, call-in timing, centre link
// - Operating processes entitlement and control messages of selected program
// - no, invalid or failed card: free programs only, no messages, no centre
// - unauthorised card type: enter Invalid and remove card power
// - no reply or logical error: enter Fail and remove card power
// - valid card: free and paid viewing, messages and centre link allowed
// - inserted card held in Power off while card power switched off, except a card already in Invalid or Fail
// - time counter runs in every receiver state except Dead, and in Dead as well when BATTERY_TIMER is set
// - time corrected from broadcast offset tables while receiving
// - Dead to Standby powers front end and initialises time unless battery kept it
// - sub power off keeps only minimum circuitry powered
// - card insertion in Standby/Operating, or main power on, reads card defaults if card power is requested
`timescale 1ns/1ps
`default_nettype none
module rcsc_controller
  import rcsc_pkg::*;
#(
  parameter bit RESUME_LAST = 1'b0, // variant that returns to the previous state
  parameter bit BATTERY_TIMER = 1'b0, // timer kept alive through Dead by battery
  parameter int TICK_DIV = TICK_CYCLES, // cycles per time tick
  parameter int SETTLE_CYCLES = CARD_SETTLE_CYCLES // card power settle time
)(
  input wire logic clk_sys, // system clock, 40 MHz
  input wire logic reset, // sync reset, active high
  input wire logic main_power_on, // main switch on and mains present
  input wire logic sub_power_on, // user sub power level
  input wire logic card_present, // card detect level
  input wire logic card_power_req, // software wants card powered
  input wire logic card_type_done, // pulse: card type check finished
  input wire logic card_type_ok, // with done: card is an authorised type
  input wire logic card_no_reply, // pulse: card did not answer
  input wire logic card_logic_err, // pulse: logical error on card link
  input wire logic broadcast_rx, // broadcast signal currently received
  input wire logic tot_valid, // pulse: time offset table received
  input wire logic [TIME_W-1:0] tot_time, // time from the offset table
  output logic [1:0] rx_state, // receiver state code
  output logic [2:0] card_state, // card state code
  output logic front_end_power, // tuner/front end powered
  output logic full_power, // full circuitry powered (sub on)
  output logic retune_last, // pulse: retune last viewed channel
  output logic time_init_req, // waiting for an offset table to set time
  output logic card_vcc, // card supply enable
  output logic card_read_defaults, // pulse: read card default data
  output logic card_classify, // classification in progress
  output logic scrambled_en, // paid/scrambled program selection allowed
  output logic emm_en, // entitlement messages processed
  output logic emm_designated_only, // only designated-channel entitlement messages
  output logic ecm_en, // control messages processed
  output logic poweron_ctrl_en, // power-on control evaluation active
  output logic callin_en, // call-in timing and centre link allowed
  output logic [TIME_W-1:0] time_now // absolute time
);
  rcsc_rx_t rx_r, rx_nxt, last_rx_r;
  rcsc_card_t cd_r, cd_nxt;
  logic [31:0] settle_r;
  logic card_seen_r, time_init_r;
  logic front_r, full_r, retune_r, vcc_r, rdef_r, clsf_r;
  logic scr_r, emm_r, emmd_r, ecm_r, pwc_r, call_r;
  logic [TIME_W-1:0] time_w;

  // receiver transitions; main power loss overrides everything
  wire leave_dead = (rx_r == RCSC_RX_DEAD) && main_power_on;
  always_comb
  begin
    rx_nxt = rx_r;
    if (!main_power_on)
      rx_nxt = RCSC_RX_DEAD;
    else
      unique case (rx_r)
        RCSC_RX_DEAD:
          rx_nxt = (RESUME_LAST && last_rx_r == RCSC_RX_OPERATING) ?
                   RCSC_RX_OPERATING : RCSC_RX_STANDBY;
        RCSC_RX_STANDBY:
          if (sub_power_on)
            rx_nxt = RCSC_RX_OPERATING;
        RCSC_RX_OPERATING:
          if (!sub_power_on)
            rx_nxt = RCSC_RX_STANDBY;
        default:
          rx_nxt = RCSC_RX_DEAD;
      endcase
  end

  // card transitions; removal and power off win over link events
  wire settle_done = (settle_r == 32'(SETTLE_CYCLES - 1));
  wire card_fault = card_no_reply || card_logic_err;
  wire rx_live = (rx_nxt != RCSC_RX_DEAD);
  always_comb
  begin
    cd_nxt = cd_r;
    if (!card_present)
      cd_nxt = RCSC_CD_NONE;
    else if (!rx_live)
      cd_nxt = RCSC_CD_POWEROFF;
    else
      unique case (cd_r)
        RCSC_CD_NONE:
          cd_nxt = card_power_req ? RCSC_CD_POWERUP : RCSC_CD_POWEROFF;
        RCSC_CD_POWEROFF:
          if (card_power_req)
            cd_nxt = RCSC_CD_POWERUP;
        RCSC_CD_POWERUP:
          if (!card_power_req)
            cd_nxt = RCSC_CD_POWEROFF;
          else if (settle_done)
            cd_nxt = RCSC_CD_CLASSIFY;
        RCSC_CD_CLASSIFY:
          if (!card_power_req)
            cd_nxt = RCSC_CD_POWEROFF;
          else if (card_fault)
            cd_nxt = RCSC_CD_FAIL;
          else if (card_type_done)
            cd_nxt = card_type_ok ? RCSC_CD_VALID : RCSC_CD_INVALID;
        RCSC_CD_VALID:
          if (!card_power_req)
            cd_nxt = RCSC_CD_POWEROFF;
          else if (card_fault)
            cd_nxt = RCSC_CD_FAIL;
        RCSC_CD_INVALID, RCSC_CD_FAIL:
          cd_nxt = cd_r; // isolated until the card is pulled or the receiver goes Dead
        default:
          cd_nxt = RCSC_CD_NONE;
      endcase
  end

  // state registers; last state kept for the resume variant
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      rx_r <= RCSC_RX_DEAD;
      last_rx_r <= RCSC_RX_STANDBY;
      cd_r <= RCSC_CD_NONE;
    end
    else
    begin
      rx_r <= rx_nxt;
      if (rx_r != RCSC_RX_DEAD)
        last_rx_r <= rx_r;
      cd_r <= cd_nxt;
    end
  end

  // settle counter only runs in power-up
  always_ff @(posedge clk_sys)
  begin
    if (reset || cd_r != RCSC_CD_POWERUP || settle_done)
      settle_r <= 32'h0;
    else
      settle_r <= settle_r + 32'h1;
  end

  // defaults are read on a fresh insertion with the receiver up, or on main power-on, while card power is requested
  wire fresh_card = card_present && !card_seen_r && (rx_r != RCSC_RX_DEAD);
  wire rdef_nxt = (fresh_card || (leave_dead && card_present)) && card_power_req;
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      card_seen_r <= 1'b0;
    else
      card_seen_r <= card_present && rx_live; // next state, so main power-on with a card pulses once
  end

  // time init wait: set when leaving Dead unless BATTERY_TIMER, cleared when a table arrives
  wire tinit_nxt = (leave_dead && !BATTERY_TIMER) ? 1'b1 :
                   (tot_valid && broadcast_rx) ? 1'b0 :
                   (rx_nxt == RCSC_RX_DEAD) ? 1'b0 : time_init_r;
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      time_init_r <= 1'b0;
    else
      time_init_r <= tinit_nxt;
  end

  // time counter stops in Dead unless battery backed
  wire time_run = (rx_r != RCSC_RX_DEAD) || BATTERY_TIMER;
  wire time_load = tot_valid && broadcast_rx && (rx_r != RCSC_RX_DEAD);
  rcsc_time_counter #(
    .TICK_DIV(TICK_DIV)
  ) u_time (
    .clk_sys(clk_sys),
    .reset(reset),
    .run(time_run),
    .load(time_load),
    .load_value(tot_time),
    .time_now(time_w)
  );

  // gating decoded from the next states so outputs line up with state registers
  wire nx_standby = (rx_nxt == RCSC_RX_STANDBY);
  wire nx_oper = (rx_nxt == RCSC_RX_OPERATING);
  wire nx_valid = (cd_nxt == RCSC_CD_VALID);
  wire nx_vcc = (cd_nxt == RCSC_CD_POWERUP) || (cd_nxt == RCSC_CD_CLASSIFY) || nx_valid;
  wire scr_nxt = nx_oper && nx_valid;
  wire ecm_nxt = nx_oper && nx_valid;
  wire emm_nxt = (nx_oper || nx_standby) && nx_valid;
  wire emmd_nxt = nx_standby && nx_valid;
  wire pwc_nxt = nx_standby;
  wire call_nxt = (nx_oper || nx_standby) && nx_valid;
  wire front_nxt = nx_oper || (nx_standby && (pwc_nxt || time_init_r || tinit_nxt));
  wire full_nxt = nx_oper;
  wire retune_nxt = leave_dead && nx_oper;

  // registered outputs
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      front_r <= 1'b0;
      full_r <= 1'b0;
      retune_r <= 1'b0;
      vcc_r <= 1'b0;
      rdef_r <= 1'b0;
      clsf_r <= 1'b0;
      scr_r <= 1'b0;
      emm_r <= 1'b0;
      emmd_r <= 1'b0;
      ecm_r <= 1'b0;
      pwc_r <= 1'b0;
      call_r <= 1'b0;
    end
    else
    begin
      front_r <= front_nxt;
      full_r <= full_nxt;
      retune_r <= retune_nxt;
      vcc_r <= nx_vcc;
      rdef_r <= rdef_nxt;
      clsf_r <= (cd_nxt == RCSC_CD_CLASSIFY);
      scr_r <= scr_nxt;
      emm_r <= emm_nxt;
      emmd_r <= emmd_nxt;
      ecm_r <= ecm_nxt;
      pwc_r <= pwc_nxt;
      call_r <= call_nxt;
    end
  end

  assign rx_state = rx_r;
  assign card_state = cd_r;
  assign front_end_power = front_r;
  assign full_power = full_r;
  assign retune_last = retune_r;
  assign time_init_req = time_init_r;
  assign card_vcc = vcc_r;
  assign card_read_defaults = rdef_r;
  assign card_classify = clsf_r;
  assign scrambled_en = scr_r;
  assign emm_en = emm_r;
  assign emm_designated_only = emmd_r;
  assign ecm_en = ecm_r;
  assign poweron_ctrl_en = pwc_r;
  assign callin_en = call_r;
  assign time_now = time_w;
endmodule
`default_nettype wire

/* File: bench/rcsc_chk.sv */
// rcsc_chk: port assertions for the receiver and card state controller
`timescale 1ns/1ps
`default_nettype none
module rcsc_chk (
  input wire logic clk_sys, // clock
  input wire logic reset, // sync reset
  input wire logic main_power_on, // main level
  input wire logic sub_power_on, // sub level
  input wire logic card_present, // detect
  input wire logic card_power_req, // power wish
  input wire logic card_type_done, // type result
  input wire logic card_type_ok, // type verdict
  input wire logic card_no_reply, // silence
  input wire logic card_logic_err, // bad frame
  input wire logic [1:0] rx_state, // receiver
  input wire logic [2:0] card_state, // card
  input wire logic card_vcc, // card supply
  input wire logic scrambled_en, // paid view
  input wire logic emm_en, // entitlement
  input wire logic ecm_en, // control msgs
  input wire logic callin_en // centre link
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // a card that stays in the slot and powered while its verdict arrives
  sequence s_held;
    card_present && card_power_req && main_power_on;
  endsequence
  sequence s_reject;
    card_state == 3'h2 && card_type_done && !card_type_ok;
  endsequence
  sequence s_fault;
    card_state == 3'h3 && (card_no_reply || card_logic_err);
  endsequence
  main_up_a: assert property (rx_state == 2'h0 && main_power_on |=> rx_state == 2'h1)
    else $error("main on in dead did not give standby");
  main_off_a: assert property (!main_power_on |=> rx_state == 2'h0)
    else $error("main off did not give dead");
  sub_up_a: assert property (rx_state == 2'h1 && main_power_on && sub_power_on |=> rx_state == 2'h2)
    else $error("sub on in standby did not give operating");
  sub_down_a: assert property (rx_state == 2'h2 && main_power_on && !sub_power_on |=> rx_state == 2'h1)
    else $error("sub off in operating did not give standby");
  // enables must never outlive a bad or missing card
  gate_bad_a: assert property (card_state inside {3'h0, 3'h4, 3'h6} |-> !(scrambled_en || emm_en || ecm_en || callin_en))
    else $error("messages or paid view enabled without valid card");
  reject_card_a: assert property (s_reject and s_held |=> card_state == 3'h4 && !card_vcc)
    else $error("unauthorised card not isolated");
  fail_card_a: assert property (s_fault and s_held |=> card_state == 3'h6 && !card_vcc)
    else $error("faulty card not isolated");
  vcc_off_a: assert property (card_present && !card_power_req |=> card_state == 3'h5 && !card_vcc)
    else $error("unpowered card not held in power off");
  removal_a: assert property (!card_present |=> card_state == 3'h0)
    else $error("removed card not cleared");
  classify_first_a: assert property (scrambled_en || emm_en || ecm_en |-> card_state == 3'h3)
    else $error("message work enabled before card classified valid");
endmodule
bind rcsc_controller rcsc_chk i_chk (.clk_sys, .reset, .main_power_on, .sub_power_on,
  .card_present, .card_power_req, .card_type_done, .card_type_ok, .card_no_reply,
  .card_logic_err, .rx_state, .card_state, .card_vcc, .scrambled_en, .emm_en, .ecm_en,
  .callin_en);
`default_nettype wire

/* File: bench/rcsc_card_model.sv */
// rcsc_card_model: behavioural smart card answering type checks and faults
`timescale 1ns/1ps
`default_nettype none
module rcsc_card_model (
  input wire logic clk_sys, // clock
  input wire logic card_vcc, // supply
  input wire logic card_classify, // type asked
  input wire logic authorised, // card kind
  input wire logic [3:0] dly, // answer latency
  input wire logic [1:0] fault_cmd, // 1 silent, 2 garbled
  output logic card_type_done, // verdict pulse
  output logic card_type_ok, // verdict
  output logic card_no_reply, // silence
  output logic card_logic_err // bad frame
);
  logic [3:0] wait_r = 4'h0;
  initial {card_type_done, card_type_ok, card_no_reply, card_logic_err} = 4'h0;
  // an unpowered card answers nothing; verdict line toggles when not valid
  always @(posedge clk_sys)
  begin
    card_type_done <= 1'b0;
    card_type_ok <= ~card_type_ok;
    card_no_reply <= card_vcc && fault_cmd == 2'h1;
    card_logic_err <= card_vcc && fault_cmd == 2'h2;
    if (!card_vcc || !card_classify || card_type_done)
      wait_r <= dly;
    else if (wait_r != 4'h0)
      wait_r <= wait_r - 4'h1;
    else
    begin
      card_type_done <= 1'b1;
      card_type_ok <= authorised;
    end
  end
endmodule
`default_nettype wire

/* File: bench/rcsc_controller_test.sv */
// rcsc_controller_test: self-checking bench for the receiver and card controller
`timescale 1ns/1ps
`default_nettype none
module rcsc_controller_test;
  import rcsc_pkg::*;
  logic clk_sys = 1'b0, reset, main_power_on, sub_power_on, card_present, card_power_req;
  logic card_type_done, card_type_ok, card_no_reply, card_logic_err, broadcast_rx, tot_valid;
  logic front_end_power, full_power, time_init_req, card_vcc, card_read_defaults, card_classify;
  logic scrambled_en, emm_en, emm_designated_only, ecm_en, poweron_ctrl_en, callin_en;
  logic authorised, retune_last;
  int n_rdef = 0;
  int n_retune = 0;
  logic [1:0] rx_state, fault_cmd;
  logic [2:0] card_state;
  logic [3:0] dly;
  logic [4:0] last_st = 5'h00;
  logic [TIME_W-1:0] tot_time, time_now, t0;
  logic [4:0] exp_q[$];
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  rcsc_controller #(.TICK_DIV(4), .SETTLE_CYCLES(3)) i_dut (.clk_sys, .reset, .main_power_on,
    .sub_power_on, .card_present, .card_power_req, .card_type_done, .card_type_ok,
    .card_no_reply, .card_logic_err, .broadcast_rx, .tot_valid, .tot_time, .rx_state,
    .card_state, .front_end_power, .full_power, .retune_last, .time_init_req, .card_vcc,
    .card_read_defaults, .card_classify, .scrambled_en, .emm_en, .emm_designated_only,
    .ecm_en, .poweron_ctrl_en, .callin_en, .time_now);
  rcsc_card_model i_card (.clk_sys, .card_vcc, .card_classify, .authorised, .dly, .fault_cmd,
    .card_type_done, .card_type_ok, .card_no_reply, .card_logic_err);
  always #12.5 clk_sys = ~clk_sys;
  task automatic check(input logic [TIME_W-1:0] seen, input logic [TIME_W-1:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // a card goes in while operating; the notes follow its expected path
  task automatic insert(input logic ok, input logic req);
    dly <= 4'($urandom_range(0, 7));
    authorised <= ok;
    card_power_req <= req;
    card_present <= 1'b1;
    if (req)
    begin
      exp_q.push_back(5'h11);
      exp_q.push_back(5'h12);
      exp_q.push_back(ok ? 5'h13 : 5'h14);
    end
    else
      exp_q.push_back(5'h15);
    cyc(25);
  endtask
  task automatic pull(input logic [4:0] nxt);
    card_present <= 1'b0;
    exp_q.push_back(nxt);
    cyc(3);
  endtask
  // random switching with no card; a reference of the receiver rules notes every change
  task automatic shuffle(input int n);
    logic m, s;
    logic [1:0] rx_m, rx_p;
    rx_m = 2'h1;
    for (int i = 0; i <= n; i++)
    begin
      m = (i == n) || ($urandom_range(0, 3) != 0); // main mostly on so upper states are reached
      s = (i != n) && 1'($urandom);
      main_power_on <= m;
      sub_power_on <= s;
      card_power_req <= (i != n) && 1'($urandom);
      broadcast_rx <= (i != n) && 1'($urandom);
      tot_valid <= (i != n) && 1'($urandom);
      repeat (3)
      begin
        rx_p = !m ? 2'h0 : (rx_m == 2'h0) ? 2'h1 : (s ? 2'h2 : 2'h1);
        if (rx_p != rx_m)
          exp_q.push_back({rx_p, 3'h0});
        rx_m = rx_p;
        cyc(1);
      end
    end
  endtask
  // each change of state takes the oldest note; order matters, not latency
  always @(posedge clk_sys)
  begin
    #1;
    if (!reset && {rx_state, card_state} !== last_st)
      check({rx_state, card_state}, exp_q.size() ? exp_q.pop_front() : 5'h1f);
    last_st = {rx_state, card_state};
    // pulses counted once per cycle they stand
    n_rdef += (card_read_defaults === 1'b1);
    n_retune += (retune_last === 1'b1);
  end
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      end_sim();
    end
  end
  initial
  begin
    reset = 1'b1;
    {main_power_on, sub_power_on, card_present, card_power_req, broadcast_rx, tot_valid} = 6'h00;
    {authorised, dly, fault_cmd, tot_time} = '0;
    void'($urandom(84));
    cyc(3);
    reset <= 1'b0;
    main_power_on <= 1'b1;
    exp_q.push_back(5'h08);
    cyc(3);
    check({time_init_req, front_end_power, poweron_ctrl_en, full_power}, 4'he);
    repeat (2)
    begin
      sub_power_on <= 1'b1;
      exp_q.push_back(5'h10);
      cyc(3);
      check(full_power, 1'b1);
      sub_power_on <= 1'b0;
      exp_q.push_back(5'h08);
      cyc(3);
    end
    sub_power_on <= 1'b1;
    exp_q.push_back(5'h10);
    cyc(3);
    $display("power states done");
    insert(1'b1, 1'b1);
    check({scrambled_en, ecm_en, emm_en, callin_en}, 4'hf);
    fault_cmd <= 2'($urandom_range(1, 2));
    cyc(1);
    fault_cmd <= 2'h0;
    exp_q.push_back(5'h16);
    cyc(3);
    check({card_vcc, scrambled_en, ecm_en, emm_en, callin_en}, 5'h00);
    pull(5'h10);
    insert(1'b0, 1'b1);
    check({card_vcc, scrambled_en, ecm_en, emm_en, callin_en}, 5'h00);
    pull(5'h10);
    $display("card faults done");
    insert(1'b1, 1'b0);
    check(card_vcc, 1'b0);
    card_power_req <= 1'b1;
    exp_q.push_back(5'h11);
    exp_q.push_back(5'h12);
    exp_q.push_back(5'h13);
    cyc(25);
    sub_power_on <= 1'b0;
    exp_q.push_back(5'h0b);
    cyc(3);
    check({scrambled_en, ecm_en, emm_en, callin_en, emm_designated_only}, 5'h07);
    pull(5'h08);
    $display("card power done");
    check(n_rdef, 2);
    shuffle(40);
    $display("random power done");
    t0 = time_now;
    cyc(40);
    check(time_now - t0, 40'h0a);
    broadcast_rx <= 1'b1;
    tot_time <= {1'b0, 39'($urandom)};
    tot_valid <= 1'b1;
    cyc(1);
    tot_valid <= 1'b0;
    cyc(1);
    check(time_now, tot_time);
    check(time_init_req, 1'b0);
    broadcast_rx <= 1'b0;
    tot_time <= {1'b1, 39'h0};
    tot_valid <= 1'b1;
    cyc(1);
    tot_valid <= 1'b0;
    cyc(3);
    check(time_now[39], 1'b0);
    main_power_on <= 1'b0;
    exp_q.push_back(5'h00);
    cyc(3);
    check(exp_q.size(), 0);
    // a card waiting in a dead receiver is read once when main power returns
    authorised <= 1'b1;
    card_power_req <= 1'b1;
    card_present <= 1'b1;
    exp_q.push_back(5'h05);
    cyc(3);
    main_power_on <= 1'b1;
    exp_q.push_back(5'h09);
    exp_q.push_back(5'h0a);
    exp_q.push_back(5'h0b);
    cyc(25);
    check(n_rdef, 3);
    check(exp_q.size(), 0);
    check(n_retune, 0);
    $display("time and shutdown done");
    end_sim();
  end
endmodule
`default_nettype wire
